/* File: shared/audio_rx_pkg.sv */
package audio_rx_pkg;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] OFS_RX_WORD_BUFFER = 8'h00; // received word, read only
  localparam logic [7:0] OFS_RX_STATUS      = 8'h04; // buffer full, overrun
  localparam logic [7:0] OFS_RX_WORD_MASK   = 8'h64; // pass or pad per bit
  localparam logic [7:0] OFS_RX_STREAM_FMT  = 8'h68; // stream format fields

  // ****************************************************************
  // field layouts and reset values
  // ****************************************************************
  localparam int          FMT_W           = 18;           // implemented format bits
  localparam logic [31:0] MASK_RESET      = 32'h00000000; // all bits padded
  localparam int          STAT_FULL_BIT   = 0;            // word waiting
  localparam int          STAT_OVR_BIT    = 1;            // word lost
  localparam logic [1:0]  PAD_ZERO        = 2'h0;         // pad with zeros
  localparam logic [1:0]  PAD_ONE         = 2'h1;         // pad with ones
  localparam logic [1:0]  PAD_COPY        = 2'h2;         // pad with chosen bit
  localparam logic [1:0]  DLY_MAX         = 2'h2;         // largest legal delay
  localparam logic [5:0]  SLOT_BITS_MAX   = 6'h20;        // 32-bit slot

  // format register image, laid out from bit 17 down to bit 0
  typedef struct packed {
    logic [1:0] rx_first_bit_delay;  // bits 17-16
    logic       rx_bit_order_select; // bit 15
    logic [1:0] rx_pad_mode;         // bits 14-13
    logic [4:0] rx_pad_bit_index;    // bits 12-8
    logic [3:0] rx_slot_width;       // bits 7-4
    logic       rx_bus_select;       // bit 3
    logic [2:0] rx_rotate_amount;    // bits 2-0
  } fmt_t;

  localparam fmt_t FMT_RESET = '0; // all fields zero after reset

  // link-side settings that cross into the bit clock domain
  typedef struct packed {
    logic [1:0] delay; // first bit delay
    logic [5:0] bits;  // slot length in bits
  } link_cfg_t;

  // link settings that match FMT_RESET, so the link side agrees after reset
  localparam link_cfg_t CFG_RESET = '{delay: 2'h0, bits: SLOT_BITS_MAX};

  // slot length from the code; odd codes 3h..Fh give 8..32, others fall to 32
  function automatic logic [5:0] slot_bits(input logic [3:0] code);
    logic [5:0] n;
    n = SLOT_BITS_MAX;
    if (code[0] && code >= 4'h3) begin
      // widened first so the 32-bit code cannot wrap to zero
      n = {1'b0, code, 1'b0} + 6'h2;
    end
    return n;
  endfunction : slot_bits

endpackage : audio_rx_pkg

/* File: src/rx_format_core.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_format_core
  import audio_rx_pkg::*;
(
  input  wire logic [31:0] raw,     // slot word as shifted in
  input  wire fmt_t        fmt,     // format settings
  input  wire logic [31:0] mask,    // one passes, zero pads
  output logic      [31:0] aligned, // after reversal and rotation
  output logic      [31:0] word     // after masking and padding
);

  // ****************************************************************
  // bit reversal, one generate loop per bit
  // ****************************************************************
  logic [31:0] flipped; // raw word mirrored
  logic [31:0] rev_w;   // reversal stage result
  logic [63:0] dbl;     // doubled word for rotation
  logic [4:0]  rot_amt; // rotation in bit positions
  logic        pad_bit; // value used in copy mode

  for (genvar i = 0; i < 32; i++) begin : g_flip
    assign flipped[i] = raw[31-i];
  end

  // msb-first streams are mirrored, lsb-first pass straight
  assign rev_w = fmt.rx_bit_order_select ? flipped : raw;

  // ****************************************************************
  // rotate right by four times the setting
  // ****************************************************************
  assign rot_amt = {fmt.rx_rotate_amount, 2'b00};
  assign dbl     = {rev_w, rev_w} >> rot_amt;
  assign aligned = dbl[31:0];

  // copy-mode pad source indexes the reader's view of the word
  assign pad_bit = aligned[fmt.rx_pad_bit_index];

  // ****************************************************************
  // masking and padding, one generate loop per bit
  // ****************************************************************
  for (genvar i = 0; i < 32; i++) begin : g_mask
    always_comb begin
      if (mask[i]) begin
        word[i] = aligned[i];
      end else begin
        // reserved pad mode behaves as zero padding
        unique case (fmt.rx_pad_mode)
          PAD_ONE:  word[i] = 1'b1;
          PAD_COPY: word[i] = pad_bit;
          default:  word[i] = 1'b0;
        endcase
      end
    end
  end

endmodule : rx_format_core
`default_nettype wire

/* File: src/audio_rx_format_unit.sv */
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module audio_rx_format_unit
  import audio_rx_pkg::*;
#(
  parameter int ADDR_W = 8 // apb address width
)(
  input  wire logic              CLK_SYS,           // system clock
  input  wire logic              RESET,             // async, active high
  input  wire logic              PSEL,              // apb select
  input  wire logic              PENABLE,           // apb access phase
  input  wire logic              PWRITE,            // apb direction
  input  wire logic [ADDR_W-1:0] PADDR,             // apb byte address
  input  wire logic [31:0]       PWDATA,            // apb write data
  output logic      [31:0]       PRDATA,            // apb read data
  output logic                   PREADY,            // apb ready
  output logic                   PSLVERR,           // apb error
  input  wire logic              RX_BIT_CLOCK_PIN,  // link bit clock
  input  wire logic              RX_FRAME_SYNC_PIN, // link frame sync
  input  wire logic              SERIAL_DATA_PIN,   // link serial data
  output logic                   RX_WORD_READY      // word waiting in buffer
);

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  logic [31:0] mask_r, mask_nxt;       // rx_word_mask
  fmt_t        fmt_r, fmt_nxt;         // rx_stream_format
  logic [31:0] buf_r, buf_nxt;         // rx_word_buffer
  logic        full_r, full_nxt;       // word not yet read
  logic        ovr_r, ovr_nxt;         // word overwritten unread
  logic        acc;                    // access phase
  logic        wr, rd;                 // qualified write, read
  logic        hit;                    // address maps to a register
  logic [7:0]  ofs;                    // low address byte
  logic        evt;                    // new slot word arrived
  logic [31:0] link_word;              // slot word from link side
  logic [31:0] aligned;                // reversed and rotated word
  logic [31:0] fmt_word;               // formatted word

  assign acc     = PSEL && PENABLE;
  assign wr      = acc && PWRITE;
  assign rd      = acc && !PWRITE;
  assign ofs     = 8'(PADDR);
  assign PREADY  = 1'b1; // zero wait states
  assign hit     = (ofs == OFS_RX_WORD_BUFFER) || (ofs == OFS_RX_STATUS) ||
                   (ofs == OFS_RX_WORD_MASK) || (ofs == OFS_RX_STREAM_FMT);
  assign PSLVERR = acc && !hit;
  assign RX_WORD_READY = full_r;

  // read mux over register flops; reserved and unmapped read zero
  always_comb begin
    PRDATA = 32'h00000000;
    if (PSEL) begin
      unique case (ofs)
        OFS_RX_WORD_BUFFER: PRDATA = buf_r;
        OFS_RX_STATUS:      PRDATA = 32'({ovr_r, full_r});
        OFS_RX_WORD_MASK:   PRDATA = mask_r;
        OFS_RX_STREAM_FMT:  PRDATA = 32'(fmt_r);
        default:            PRDATA = 32'h00000000;
      endcase
    end
  end

  // next values of the software registers and the buffer flags
  always_comb begin
    mask_nxt = mask_r;
    fmt_nxt  = fmt_r;
    buf_nxt  = buf_r;
    full_nxt = full_r;
    ovr_nxt  = ovr_r;
    if (wr && ofs == OFS_RX_WORD_MASK) begin
      mask_nxt = PWDATA;
    end
    if (wr && ofs == OFS_RX_STREAM_FMT) begin
      fmt_nxt = fmt_t'(PWDATA[FMT_W-1:0]);
    end
    // reading the buffer empties it
    if (rd && ofs == OFS_RX_WORD_BUFFER) begin
      full_nxt = 1'b0;
    end
    // write one clears the overrun flag
    if (wr && ofs == OFS_RX_STATUS && PWDATA[STAT_OVR_BIT]) begin
      ovr_nxt = 1'b0;
    end
    // arriving word wins over a same-cycle clear
    if (evt) begin
      buf_nxt  = fmt_word;
      full_nxt = 1'b1;
      if (full_r && !(rd && ofs == OFS_RX_WORD_BUFFER)) begin
        ovr_nxt = 1'b1;
      end
    end
  end

  // register the bus-side state
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      mask_r <= MASK_RESET;
      fmt_r  <= FMT_RESET;
      buf_r  <= 32'h00000000;
      full_r <= 1'b0;
      ovr_r  <= 1'b0;
    end else begin
      mask_r <= mask_nxt;
      fmt_r  <= fmt_nxt;
      buf_r  <= buf_nxt;
      full_r <= full_nxt;
      ovr_r  <= ovr_nxt;
    end
  end

  // ****************************************************************
  // format pipeline
  // ****************************************************************
  rx_format_core u_core (
    .raw     (link_word),
    .fmt     (fmt_r),
    .mask    (mask_r),
    .aligned (aligned),
    .word    (fmt_word)
  );

  // ****************************************************************
  // crossing: slot toggle into system domain
  // ****************************************************************
  logic       tog_r;          // link side slot toggle
  logic [2:0] tsy_r, tsy_nxt; // three-stage toggle sampler

  always_comb begin
    tsy_nxt = {tsy_r[1:0], tog_r};
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      tsy_r <= 3'h0;
    end else begin
      tsy_r <= tsy_nxt;
    end
  end

  // stages two and three disagree once per slot; link word is stable then
  assign evt = tsy_r[1] ^ tsy_r[2];

  // ****************************************************************
  // crossing: link settings into bit clock domain
  // ****************************************************************
  link_cfg_t cfg_src;                 // settings in system domain
  link_cfg_t cs1_r, cs2_r, cs3_r;     // three-stage sampler
  link_cfg_t cfg_r, cfg_nxt;          // accepted settings

  assign cfg_src.delay = (fmt_r.rx_first_bit_delay > DLY_MAX) ? DLY_MAX
                                                              : fmt_r.rx_first_bit_delay;
  assign cfg_src.bits  = slot_bits(fmt_r.rx_slot_width);

  // accept only when second and third stage agree
  always_comb begin
    cfg_nxt = (cs2_r == cs3_r) ? cs2_r : cfg_r;
  end

  always_ff @(posedge RX_BIT_CLOCK_PIN or posedge RESET) begin
    if (RESET) begin
      cs1_r <= CFG_RESET;
      cs2_r <= CFG_RESET;
      cs3_r <= CFG_RESET;
      cfg_r <= CFG_RESET;
    end else begin
      cs1_r <= cfg_src;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************************************
  // link receiver on the bit clock
  // ****************************************************************
  typedef enum logic [1:0] {L_IDLE, L_WAIT, L_SHIFT} lstate_t;

  lstate_t     st_r, st_nxt;     // receiver state
  logic [1:0]  dcnt_r, dcnt_nxt; // delay cycles left
  logic [5:0]  bcnt_r, bcnt_nxt; // bits taken in slot
  logic [31:0] sh_r, sh_nxt;     // shift register, fills from bit 31
  logic [31:0] wrd_r, wrd_nxt;   // completed slot word
  logic        tog_nxt;          // toggled per completed slot

  assign link_word = wrd_r;

  // next state of the receiver
  always_comb begin
    st_nxt   = st_r;
    dcnt_nxt = dcnt_r;
    bcnt_nxt = bcnt_r;
    sh_nxt   = sh_r;
    wrd_nxt  = wrd_r;
    tog_nxt  = tog_r;
    unique case (st_r)
      L_IDLE: begin
        if (RX_FRAME_SYNC_PIN) begin
          if (cfg_r.delay == 2'h0) begin
            // first bit shares the frame sync cycle
            sh_nxt   = {SERIAL_DATA_PIN, 31'h0};
            bcnt_nxt = 6'h1;
            st_nxt   = L_SHIFT;
          end else begin
            dcnt_nxt = cfg_r.delay - 2'h1;
            st_nxt   = L_WAIT;
          end
        end
      end
      L_WAIT: begin
        if (dcnt_r == 2'h0) begin
          sh_nxt   = {SERIAL_DATA_PIN, 31'h0};
          bcnt_nxt = 6'h1;
          st_nxt   = L_SHIFT;
        end else begin
          dcnt_nxt = dcnt_r - 2'h1;
        end
      end
      L_SHIFT: begin
        sh_nxt   = {SERIAL_DATA_PIN, sh_r[31:1]};
        bcnt_nxt = bcnt_r + 6'h1;
        if (bcnt_nxt == cfg_r.bits) begin
          // slot complete: hand word over and wait for next sync
          wrd_nxt = sh_nxt;
          tog_nxt = !tog_r;
          st_nxt  = L_IDLE;
        end
      end
    endcase
  end

  // register the receiver state
  always_ff @(posedge RX_BIT_CLOCK_PIN or posedge RESET) begin
    if (RESET) begin
      st_r   <= L_IDLE;
      dcnt_r <= 2'h0;
      bcnt_r <= 6'h0;
      sh_r   <= 32'h00000000;
      wrd_r  <= 32'h00000000;
      tog_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      dcnt_r <= dcnt_nxt;
      bcnt_r <= bcnt_nxt;
      sh_r   <= sh_nxt;
      wrd_r  <= wrd_nxt;
      tog_r  <= tog_nxt;
    end
  end

  // ****************************************************************
  // assertions, system domain
  // ****************************************************************
  a_mask_pass_bits: assert property (@(posedge CLK_SYS) disable iff (RESET)
    evt |=> ((buf_r & $past(mask_r)) == ($past(aligned) & $past(mask_r))))
    else $error("passed bits differ from aligned word");

  a_pad_zero_fill: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (evt && fmt_r.rx_pad_mode == PAD_ZERO) |=> ((buf_r & ~$past(mask_r)) == 32'h00000000))
    else $error("masked bits not zero");

  a_pad_one_fill: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (evt && fmt_r.rx_pad_mode == PAD_ONE) |=> ((buf_r | $past(mask_r)) == 32'hFFFFFFFF))
    else $error("masked bits not one");

  a_pad_copy_bit: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (evt && fmt_r.rx_pad_mode == PAD_COPY) |=>
      ((buf_r & ~$past(mask_r)) ==
       ({32{$past(aligned[fmt_r.rx_pad_bit_index])}} & ~$past(mask_r))))
    else $error("masked bits not copy of chosen bit");

  a_fmt_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr && ofs == OFS_RX_STREAM_FMT) |=>
      (32'(fmt_r) == {14'h0, $past(PWDATA[FMT_W-1:0])}))
    else $error("format write stored reserved bits");

  a_plain_passthru: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (!fmt_r.rx_bit_order_select && fmt_r.rx_rotate_amount == 3'h0) |-> (aligned == link_word))
    else $error("word altered with no reversal or rotation");

  a_msb_reversed: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (fmt_r.rx_bit_order_select && fmt_r.rx_rotate_amount == 3'h0) |->
      (aligned[0] == link_word[31] && aligned[31] == link_word[0]))
    else $error("msb-first word not mirrored");

  a_buffer_only_evt: assert property (@(posedge CLK_SYS) disable iff (RESET)
    !evt |=> $stable(buf_r))
    else $error("buffer changed without a slot");

  // ****************************************************************
  // assertions, link domain
  // ****************************************************************
  a_delay_zero_cap: assert property (@(posedge RX_BIT_CLOCK_PIN) disable iff (RESET)
    (st_r == L_IDLE && RX_FRAME_SYNC_PIN && cfg_r.delay == 2'h0) |=>
      (st_r == L_SHIFT && bcnt_r == 6'h1))
    else $error("zero delay did not capture at sync");

  a_delay_two_cap: assert property (@(posedge RX_BIT_CLOCK_PIN) disable iff (RESET)
    (st_r == L_IDLE && RX_FRAME_SYNC_PIN && cfg_r.delay == 2'h2) |=>
      st_r == L_WAIT ##1 st_r == L_WAIT ##1 (st_r == L_SHIFT && bcnt_r == 6'h1))
    else $error("two-cycle delay mistimed");

  a_slot_end_toggle: assert property (@(posedge RX_BIT_CLOCK_PIN) disable iff (RESET)
    (st_r == L_SHIFT && bcnt_r + 6'h1 == cfg_r.bits) |=> (tog_r != $past(tog_r) && st_r == L_IDLE))
    else $error("slot did not end at configured width");

endmodule : audio_rx_format_unit
`default_nettype wire

/* File: verif/audio_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// remote audio transmitter: bit clock, frame sync, serial data
// ****************************************************************
module audio_tx_model (
  output logic bclk,  // bit clock, still between frames but for the lead-in clocks
  output logic fsync, // frame sync, active high
  output logic sdata  // serial data, changes on falling edge
);
  localparam int LEAD = 6; // idle bit clocks ahead of each sync

  logic last; // last level put on the data line

  // idle levels at time zero
  initial begin
    bclk  = 1'b0;
    fsync = 1'b0;
    sdata = 1'b0;
    last  = 1'b0;
  end

  // one slot: sync at edge 0, bit i at edge d+i, bit 0 of the value first
  task automatic send_slot(input logic [1:0] d, input int w, input logic [31:0] bits);
    int k;
    #6.2; // keeps bit clock edges off the system clock edges
    // idle lead-in slot: the receiver needs bit clocks to take new settings
    for (k = 0; k < LEAD; k++) begin
      fsync = 1'b0;
      last  = ~last;
      sdata = last;
      #15 bclk = 1'b1;
      #15 bclk = 1'b0;
    end
    for (k = 0; k < d + w; k++) begin
      fsync = (k == 0);
      if (k >= d) begin
        last = bits[k-d];
      end else begin
        last = ~last; // filler that changes every cycle
      end
      sdata = last;
      #15 bclk = 1'b1;
      #15 bclk = 1'b0;
    end
    fsync = 1'b0;
    sdata = ~last; // released line shows no stale bit
  endtask : send_slot
endmodule : audio_tx_model
`default_nettype wire

/* File: verif/tb_audio_rx_format_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_audio_rx_format_unit;
  import audio_rx_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        clk_sys;         // system clock
  logic        reset;           // async reset
  logic        psel;            // apb select
  logic        penable;         // apb access phase
  logic        pwrite;          // apb direction
  logic [7:0]  paddr;           // apb address
  logic [31:0] pwdata;          // apb write data
  logic [31:0] prdata;          // apb read data
  logic        pready;          // apb ready
  logic        pslverr;         // apb error
  wire         bclk;            // link bit clock
  wire         fsync;           // link frame sync
  wire         sdata;           // link data
  logic        rx_word_ready;   // word waiting
  int          failures;        // mismatches
  int          samples_checked; // comparisons

  audio_rx_format_unit #(.ADDR_W(8)) uut (
    .CLK_SYS(clk_sys), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_BIT_CLOCK_PIN(bclk), .RX_FRAME_SYNC_PIN(fsync), .SERIAL_DATA_PIN(sdata),
    .RX_WORD_READY(rx_word_ready));

  audio_tx_model src (.bclk(bclk), .fsync(fsync), .sdata(sdata));

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // compare, report and bus tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check_word(r, exp);
    check_bit(e, eerr);
  endtask : rd_check

  // ****************************************************************
  // expected word: place, reverse, rotate, mask and pad
  // ****************************************************************
  function automatic logic [31:0] model(fmt_t f, logic [31:0] m, logic [31:0] b, int w);
    logic [31:0] a;
    logic [31:0] r;
    logic [31:0] o;
    int          i;
    int          s;
    a = b << (32 - w);
    r = a;
    for (i = 0; i < 32; i++) begin
      if (f.rx_bit_order_select) r[i] = a[31-i];
    end
    s = 4 * f.rx_rotate_amount;
    a = (s == 0) ? r : ((r >> s) | (r << (32 - s)));
    for (i = 0; i < 32; i++) begin
      o[i] = m[i] ? a[i] : ((f.rx_pad_mode == PAD_ONE) | ((f.rx_pad_mode == PAD_COPY) & a[f.rx_pad_bit_index]));
    end
    return o;
  endfunction : model

  // configure, send one slot, read it back
  task automatic xfer(input fmt_t f, input logic [31:0] m, input logic [31:0] b);
    int n;
    int w;
    w = 2 * f.rx_slot_width + 2;
    wr(OFS_RX_STREAM_FMT, {14'h0, f});
    wr(OFS_RX_WORD_MASK, m);
    repeat (30) @(posedge clk_sys); // pause only; link side takes config during the send_slot lead-in
    src.send_slot(f.rx_first_bit_delay, w, b);
    n = 0;
    while (rx_word_ready !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 400) begin
      failures++;
      report_and_stop();
    end
    rd_check(OFS_RX_STATUS, 32'h00000001, 1'b0);
    rd_check(OFS_RX_WORD_BUFFER, model(f, m, b, w), 1'b0);
    @(posedge clk_sys);
    check_bit(rx_word_ready, 1'b0);
  endtask : xfer

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic scen_regs();
    rd_check(OFS_RX_WORD_MASK, MASK_RESET, 1'b0);
    rd_check(OFS_RX_STREAM_FMT, 32'h00000000, 1'b0);
    rd_check(8'h10, 32'h00000000, 1'b1);
    wr(OFS_RX_STREAM_FMT, 32'hFFFFFFFF);
    rd_check(OFS_RX_STREAM_FMT, 32'h0003FFFF, 1'b0);
    wr(OFS_RX_WORD_MASK, 32'hA5A5C3C3);
    rd_check(OFS_RX_WORD_MASK, 32'hA5A5C3C3, 1'b0);
  endtask : scen_regs

  task automatic scen_delay();
    int d;
    for (d = 0; d < 3; d++) begin
      xfer('{2'(d), 1'b0, PAD_ZERO, 5'h00, 4'hF, 1'b0, 3'h0}, 32'hFFFFFFFF, 32'h8C3F21E5 ^ d);
    end
  endtask : scen_delay

  task automatic scen_width();
    int c;
    for (c = 3; c < 16; c += 2) begin
      xfer('{2'h1, 1'b0, PAD_ZERO, 5'h00, 4'(c), 1'b0, 3'h0}, ~32'h0 << (30 - 2 * c), 32'hD2B496E1);
    end
  endtask : scen_width

  task automatic scen_order_rotate();
    int r;
    for (r = 0; r < 8; r++) begin
      xfer('{2'h0, 1'(r), PAD_ZERO, 5'h00, 4'hF, 1'b0, 3'(r)}, 32'hFFFFFFFF, 32'h1234ABCD);
    end
    // msb-first with no rotation: plain mirror
    xfer('{2'h0, 1'b1, PAD_ZERO, 5'h00, 4'hF, 1'b0, 3'h0}, 32'hFFFFFFFF, 32'h1234ABCD);
  endtask : scen_order_rotate

  task automatic scen_pad();
    xfer('{2'h0, 1'b1, PAD_ZERO, 5'h1F, 4'hF, 1'b0, 3'h3}, 32'h0F0F00FF, 32'hF00F5A3C);
    xfer('{2'h0, 1'b1, PAD_ONE, 5'h00, 4'hF, 1'b0, 3'h3}, 32'h0F0F00FF, 32'h0FF0A5C3);
    xfer('{2'h0, 1'b1, PAD_COPY, 5'h1F, 4'hF, 1'b0, 3'h3}, 32'h0F0F00FF, 32'h0000000F);
    xfer('{2'h0, 1'b1, PAD_COPY, 5'h04, 4'hF, 1'b0, 3'h3}, 32'h0F0F00FF, 32'hFFFFFFF0);
  endtask : scen_pad

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    failures        = 0;
    samples_checked = 0;
    reset   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    scen_regs();
    scen_delay();
    scen_width();
    scen_order_rotate();
    scen_pad();
    report_and_stop();
  end
endmodule : tb_audio_rx_format_unit
`default_nettype wire
